/* hdl/imf_pkg.sv */
package imf_pkg;
  // bus geometry
  localparam int ADDR_W = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CEIL = 8'h69;
  localparam logic [7:0] IDX_MISC = 8'h6a;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h70;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h71;
  localparam logic [11:0] ADDR_CEIL = {2'h0, IDX_CEIL, 2'h0};
  localparam logic [11:0] ADDR_MISC = {2'h0, IDX_MISC, 2'h0};
  localparam logic [11:0] ADDR_IRQ_STAT = {2'h0, IDX_IRQ_STAT, 2'h0};
  localparam logic [11:0] ADDR_IRQ_MASK = {2'h0, IDX_IRQ_MASK, 2'h0};
  // memory_ceiling_forwarding fields
  localparam int CEIL_MSB = 7;
  localparam int CEIL_LSB = 4;
  localparam int LBIOS_EN_BIT = 3;
  localparam int VGA_EN_BIT = 2;
  localparam int LOW512_EN_BIT = 1;
  localparam logic [7:0] CEIL_RST = 8'h02;
  localparam logic [7:0] CEIL_WMASK = 8'hfe;
  // misc_status_control fields
  localparam int MISC_SERR_BIT = 15;
  localparam int MISC_RETRY_BIT = 7;
  localparam logic [15:0] MISC_RST = 16'h0000;
  // interrupt status bits
  localparam int IRQ_W = 2;
  localparam int IRQ_DT_BIT = 0;
  localparam int IRQ_FWD_BIT = 1;
  localparam logic [1:0] IRQ_RST = 2'h0;
  // legacy regions of the 24-bit isa space
  localparam logic [23:0] LOW512_LO = 24'h080000;
  localparam logic [23:0] LOW512_HI = 24'h09ffff;
  localparam logic [23:0] VGA_LO = 24'h0a0000;
  localparam logic [23:0] VGA_HI = 24'h0bffff;
  localparam logic [23:0] LBIOS_LO = 24'h0e0000;
  localparam logic [23:0] LBIOS_HI = 24'h0effff;

  typedef enum logic [1:0] {
    IMF_S_IDLE = 2'h0,
    IMF_S_RESP = 2'h1
  } imf_resp_state_t;

  function automatic logic imf_in_range(input logic [23:0] a,
                                        input logic [23:0] lo,
                                        input logic [23:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction
endpackage

/* hdl/imf_reg_if.sv */
`timescale 1ns/1ps
interface imf_reg_if;
  logic wr_en;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic rd_en;
  logic [11:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  modport slv (
    output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    input wr_err, rd_data, rd_err
  );
  modport regs (
    input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    output wr_err, rd_data, rd_err
  );
endinterface

/* hdl/imf_axil_slave.sv */
`timescale 1ns/1ps
module imf_axil_slave (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read channels
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // register side
  imf_reg_if.slv bus
);
  imf_pkg::imf_resp_state_t wr_state;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // a ready low means its channel holds an item
  assign bus.wr_en = !s_axi_awready && !s_axi_wready &&
                     (wr_state == imf_pkg::IMF_S_IDLE);
  assign bus.wr_addr = awaddr_q;
  assign bus.wr_data = wdata_q;
  assign bus.wr_strb = wstrb_q;
  assign bus.rd_en = s_axi_arvalid && s_axi_arready;
  assign bus.rd_addr = s_axi_araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (bus.wr_en) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= imf_pkg::IMF_S_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      case (wr_state)
        imf_pkg::IMF_S_IDLE: begin
          if (bus.wr_en) begin
            wr_state <= imf_pkg::IMF_S_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= bus.wr_err ? imf_pkg::RESP_SLVERR
                                      : imf_pkg::RESP_OKAY;
          end
        end
        default: begin
          if (s_axi_bready) begin
            wr_state <= imf_pkg::IMF_S_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
      endcase
    end
  end

  // data captured at the address handshake so read side effects match it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (bus.rd_en) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= bus.rd_data;
      s_axi_rresp <= bus.rd_err ? imf_pkg::RESP_SLVERR : imf_pkg::RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

/* hdl/imf_fwd_decode.sv */
`timescale 1ns/1ps
module imf_fwd_decode (
  // access
  input wire logic [23:0] addr,
  input wire logic in_hole,
  // controls
  input wire logic [7:0] ceil_reg,
  input wire logic bios_cs_contain,
  // decision
  output logic to_pci
);
  logic below_ceil;

  // (R01) n selects n+1 mbytes
  assign below_ceil = addr[23:20] <= ceil_reg[imf_pkg::CEIL_MSB:
                                               imf_pkg::CEIL_LSB];

  always_comb begin
    // (R12) default keeps cycle on isa
    to_pci = 1'b0;
    if (in_hole) begin
      to_pci = 1'b0;
    end else if (imf_pkg::imf_in_range(addr, imf_pkg::LBIOS_LO,
                                       imf_pkg::LBIOS_HI)) begin
      // (R03) (R04) lower bios, chip-select override
      to_pci = ceil_reg[imf_pkg::LBIOS_EN_BIT] && !bios_cs_contain;
    end else if (imf_pkg::imf_in_range(addr, imf_pkg::VGA_LO,
                                       imf_pkg::VGA_HI)) begin
      // (R05) a0000 region
      to_pci = ceil_reg[imf_pkg::VGA_EN_BIT];
    end else if (imf_pkg::imf_in_range(addr, imf_pkg::LOW512_LO,
                                       imf_pkg::LOW512_HI)) begin
      // (R06) 80000 region
      to_pci = ceil_reg[imf_pkg::LOW512_EN_BIT];
    end else begin
      // (R02) below ceiling, outside hole
      to_pci = below_ceil;
    end
  end
endmodule

/* hdl/imf_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// (R01) Bits 7:4 set memory ceiling; value n means n+1 Mbytes.
// (R02) Access below ceiling and outside hole goes to PCI.
// (R03) Bit 3 forwards E0000-EFFFF accesses to PCI, else ISA.
// (R04) BIOS chip-select bit 6 set keeps lower BIOS accesses on ISA.
// (R05) Bit 2 forwards A0000-BFFFF accesses to PCI, else ISA.
// (R06) Bit 1 forwards 80000-9FFFF accesses to PCI, else ISA.
// (R07) Discard-timer SERR sets misc status bit 15.
// (R08) Writing one clears bit 15; writing zero leaves it.
// (R09) Retry bit 7 set: plain retry for CPU non-locked cycles.
// (R10) Software sets retry only with nothing pending, release active.
// (R11) Retry bit clear: CPU cycles accepted normally.
// (R12) Access no enabled condition selects stays on ISA.
module imf_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // isa master / dma memory access
  input wire logic isa_mem_valid,
  input wire logic [23:0] isa_mem_addr,
  input wire logic isa_in_hole,
  input wire logic bios_cs_contain,
  output logic fwd_valid,
  output logic fwd_to_pci,
  // delayed transaction time-out
  input wire logic dt_discard_expired,
  output logic serr_n,
  // cpu-initiated pci cycles
  input wire logic cpu_cyc_valid,
  input wire logic cpu_cyc_lock,
  output logic cpu_plain_retry,
  output logic cpu_normal,
  // interrupt
  output logic irq
);
  imf_reg_if bus ();

  logic [7:0] memory_ceiling_forwarding;
  logic serr_flag;
  logic retry_en;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic dec_to_pci;
  logic wr_ceil;
  logic wr_misc;
  logic wr_mask;
  logic rd_stat;
  logic [1:0] irq_events;
  logic [15:0] misc_status_control;

  imf_axil_slave i_imf_axil_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .bus(bus.slv)
  );

  imf_fwd_decode i_imf_fwd_decode (
    .addr(isa_mem_addr),
    .in_hole(isa_in_hole),
    .ceil_reg(memory_ceiling_forwarding),
    .bios_cs_contain(bios_cs_contain),
    .to_pci(dec_to_pci)
  );

  assign wr_ceil = bus.wr_en && (bus.wr_addr == imf_pkg::ADDR_CEIL);
  assign wr_misc = bus.wr_en && (bus.wr_addr == imf_pkg::ADDR_MISC);
  assign wr_mask = bus.wr_en && (bus.wr_addr == imf_pkg::ADDR_IRQ_MASK);
  assign rd_stat = bus.rd_en && (bus.rd_addr == imf_pkg::ADDR_IRQ_STAT);
  assign misc_status_control = {serr_flag, 7'h00, retry_en, 7'h00};

  // register read mux; reserved bits read zero
  always_comb begin
    bus.rd_err = 1'b0;
    if (bus.rd_addr == imf_pkg::ADDR_CEIL) begin
      bus.rd_data = {24'h000000, memory_ceiling_forwarding};
    end else if (bus.rd_addr == imf_pkg::ADDR_MISC) begin
      bus.rd_data = {16'h0000, misc_status_control};
    end else if (bus.rd_addr == imf_pkg::ADDR_IRQ_STAT) begin
      bus.rd_data = {30'h0, irq_stat};
    end else if (bus.rd_addr == imf_pkg::ADDR_IRQ_MASK) begin
      bus.rd_data = {30'h0, irq_mask};
    end else begin
      bus.rd_data = 32'h0000_0000;
      bus.rd_err = 1'b1;
    end
  end

  assign bus.wr_err = !((bus.wr_addr == imf_pkg::ADDR_CEIL) ||
                        (bus.wr_addr == imf_pkg::ADDR_MISC) ||
                        (bus.wr_addr == imf_pkg::ADDR_IRQ_STAT) ||
                        (bus.wr_addr == imf_pkg::ADDR_IRQ_MASK));

  // (R01) ceiling and region enables; bit 0 reserved
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      memory_ceiling_forwarding <= imf_pkg::CEIL_RST;
    end else if (wr_ceil && bus.wr_strb[0]) begin
      memory_ceiling_forwarding <= bus.wr_data[7:0] & imf_pkg::CEIL_WMASK;
    end
  end

  // (R07) (R08) sticky time-out flag, a new event beats the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serr_flag <= imf_pkg::MISC_RST[imf_pkg::MISC_SERR_BIT];
    end else if (dt_discard_expired) begin
      serr_flag <= 1'b1;
    end else if (wr_misc && bus.wr_strb[1] &&
                 bus.wr_data[imf_pkg::MISC_SERR_BIT]) begin
      serr_flag <= 1'b0;
    end
  end

  // (R09) plain retry enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      retry_en <= imf_pkg::MISC_RST[imf_pkg::MISC_RETRY_BIT];
    end else if (wr_misc && bus.wr_strb[0]) begin
      retry_en <= bus.wr_data[imf_pkg::MISC_RETRY_BIT];
    end
  end

  // (R07) serr pin pulses low for the expiry
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serr_n <= 1'b1;
    end else begin
      serr_n <= !dt_discard_expired;
    end
  end

  // (R02) (R12) registered forwarding decision
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fwd_valid <= 1'b0;
      fwd_to_pci <= 1'b0;
    end else begin
      fwd_valid <= isa_mem_valid;
      fwd_to_pci <= isa_mem_valid && dec_to_pci;
    end
  end

  // (R09) (R11) cpu cycle answer; relies on software keeping (R10)
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_plain_retry <= 1'b0;
      cpu_normal <= 1'b0;
    end else begin
      cpu_plain_retry <= cpu_cyc_valid && retry_en && !cpu_cyc_lock;
      cpu_normal <= cpu_cyc_valid && !(retry_en && !cpu_cyc_lock);
    end
  end

  // read clears, but an event in the same cycle survives
  assign irq_events = {isa_mem_valid && dec_to_pci, dt_discard_expired};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= imf_pkg::IRQ_RST;
    end else if (rd_stat) begin
      irq_stat <= irq_events;
    end else begin
      irq_stat <= irq_stat | irq_events;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= imf_pkg::IRQ_RST;
    end else if (wr_mask && bus.wr_strb[0]) begin
      irq_mask <= bus.wr_data[1:0];
    end
  end

  // one cycle behind status so the pin is a flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_access_clear;
    isa_mem_valid && !isa_in_hole;
  endsequence

  sequence s_serr_flagged;
    !serr_n && serr_flag;
  endsequence

  AST_ABOVE_CEIL: assert property ( // (R01)
    (isa_mem_valid && isa_mem_addr[23:20] >
     memory_ceiling_forwarding[7:4]) |=> fwd_valid && !fwd_to_pci)
    else $error("access above ceiling forwarded");

  AST_BELOW_CEIL: assert property ( // (R02)
    (s_access_clear and (isa_mem_addr[23:20] != 4'h0) and
     (isa_mem_addr[23:20] <= memory_ceiling_forwarding[7:4]))
    |=> fwd_valid && fwd_to_pci)
    else $error("access below ceiling not forwarded");

  AST_LBIOS: assert property ( // (R03)
    (s_access_clear and !bios_cs_contain and
     imf_pkg::imf_in_range(isa_mem_addr, 24'h0e0000, 24'h0effff))
    |=> fwd_to_pci == $past(memory_ceiling_forwarding[3]))
    else $error("lower bios forwarding wrong");

  AST_BIOS_CS: assert property ( // (R04)
    (isa_mem_valid && bios_cs_contain &&
     imf_pkg::imf_in_range(isa_mem_addr, 24'h0e0000, 24'h0effff))
    |=> !fwd_to_pci)
    else $error("lower bios forwarded despite chip-select");

  AST_VGA: assert property ( // (R05)
    (s_access_clear and
     imf_pkg::imf_in_range(isa_mem_addr, 24'h0a0000, 24'h0bffff))
    |=> fwd_to_pci == $past(memory_ceiling_forwarding[2]))
    else $error("a0000 region forwarding wrong");

  AST_LOW512: assert property ( // (R06)
    (s_access_clear and
     imf_pkg::imf_in_range(isa_mem_addr, 24'h080000, 24'h09ffff))
    |=> fwd_to_pci == $past(memory_ceiling_forwarding[1]))
    else $error("80000 region forwarding wrong");

  AST_SERR_SET: assert property ( // (R07)
    dt_discard_expired |=> s_serr_flagged ##1 serr_flag [*2])
    else $error("time-out flag not set or lost");

  AST_W1C: assert property ( // (R08)
    (serr_flag && !dt_discard_expired && wr_misc && bus.wr_strb[1])
    |=> serr_flag == !$past(bus.wr_data[15]))
    else $error("time-out flag write-one-clear wrong");

  AST_RETRY: assert property ( // (R09)
    (cpu_cyc_valid && retry_en && !cpu_cyc_lock)
    |=> cpu_plain_retry && !cpu_normal)
    else $error("plain retry not given");

  AST_NORMAL: assert property ( // (R11)
    (cpu_cyc_valid && !retry_en) |=> cpu_normal && !cpu_plain_retry)
    else $error("cycle not accepted normally");

  AST_HOLE: assert property ( // (R12)
    (isa_mem_valid && isa_in_hole) |=> fwd_valid && !fwd_to_pci)
    else $error("hole access forwarded");

  AST_FWD_IDLE: assert property ( // (R12)
    !isa_mem_valid |=> !fwd_valid && !fwd_to_pci)
    else $error("forwarding answer without an access");

  AST_SERR_PIN: assert property ( // (R07)
    !dt_discard_expired |=> serr_n)
    else $error("serr pin asserted without expiry");

  AST_LOCKED: assert property ( // (R09)
    (cpu_cyc_valid && cpu_cyc_lock) |=> cpu_normal && !cpu_plain_retry)
    else $error("locked cycle given plain retry");

  AST_IRQ: assert property (
    (dt_discard_expired && irq_mask[0]) |-> ##2 irq)
    else $error("interrupt not raised");
endmodule

/* testbench/imf_far_model.sv */
`timescale 1ns/1ps
module imf_far_model (
  // clock
  input wire logic aclk,
  // isa master / dma side
  output logic isa_mem_valid,
  output logic [23:0] isa_mem_addr,
  output logic isa_in_hole,
  // pci side
  output logic dt_discard_expired,
  output logic cpu_cyc_valid,
  output logic cpu_cyc_lock
);
  initial begin
    isa_mem_valid = 1'b0;
    isa_mem_addr = 24'h0;
    isa_in_hole = 1'b0;
    dt_discard_expired = 1'b0;
    cpu_cyc_valid = 1'b0;
    cpu_cyc_lock = 1'b0;
  end
  // qualifiers inverted after the pulse so stale values never match
  task automatic isa_access(input logic [23:0] a, input logic h);
    @(posedge aclk);
    isa_mem_valid <= 1'b1;
    isa_mem_addr <= a;
    isa_in_hole <= h;
    @(posedge aclk);
    isa_mem_valid <= 1'b0;
    isa_mem_addr <= ~a;
    isa_in_hole <= ~h;
  endtask
  task automatic cpu_cycle(input logic lk);
    @(posedge aclk);
    cpu_cyc_valid <= 1'b1;
    cpu_cyc_lock <= lk;
    @(posedge aclk);
    cpu_cyc_valid <= 1'b0;
    cpu_cyc_lock <= ~lk;
  endtask
  task automatic dt_pulse();
    @(posedge aclk);
    dt_discard_expired <= 1'b1;
    @(posedge aclk);
    dt_discard_expired <= 1'b0;
  endtask
endmodule

/* testbench/imf_tb_top.sv */
`timescale 1ns/1ps
module imf_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic isa_mem_valid, isa_in_hole, bios_cs_contain, fwd_valid, fwd_to_pci;
  logic [23:0] isa_mem_addr;
  logic dt_discard_expired, serr_n, cpu_cyc_valid, cpu_cyc_lock;
  logic cpu_plain_retry, cpu_normal, irq, lk;
  logic [7:0] ceil_v;
  int mismatches = 0;
  int cmp_count = 0;
  logic exp_fwd[$];
  logic [1:0] exp_cpu[$];
  logic [33:0] exp_rd[$];

  always #20 aclk = ~aclk;

  imf_top i_imf_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .isa_mem_valid,
    .isa_mem_addr, .isa_in_hole, .bios_cs_contain, .fwd_valid,
    .fwd_to_pci, .dt_discard_expired, .serr_n, .cpu_cyc_valid,
    .cpu_cyc_lock, .cpu_plain_retry, .cpu_normal, .irq);
  imf_far_model i_imf_far_model (.aclk, .isa_mem_valid, .isa_mem_addr,
    .isa_in_hole, .dt_discard_expired, .cpu_cyc_valid, .cpu_cyc_lock);

  task automatic chk(input string nm, input logic [33:0] e,
                     input logic [33:0] s);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // reference decision, hole and legacy windows take priority
  function automatic logic ref_fwd(input logic [23:0] a, input logic h,
                                   input logic [7:0] c, input logic b);
    if (h) return 1'b0;
    if (a >= 24'h0e0000 && a <= 24'h0effff) return c[3] & ~b;
    if (a >= 24'h0a0000 && a <= 24'h0bffff) return c[2];
    if (a >= 24'h080000 && a <= 24'h09ffff) return c[1];
    // ceiling of field plus one mbyte
    return a[23:20] <= c[7:4];
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] st, input logic [1:0] er);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && s_axi_awready === 1'b1) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (!wd && s_axi_wready === 1'b1) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bvalid", 34'h1, {33'h0, s_axi_bvalid});
    chk("bresp", {32'h0, er}, {32'h0, s_axi_bresp});
  endtask

  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    exp_rd.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask

  task automatic setc(input logic [7:0] v);
    ceil_v = v & 8'hfe;
    wr(imf_pkg::ADDR_CEIL, {24'h0, v}, 4'h1, imf_pkg::RESP_OKAY);
  endtask

  task automatic isa(input logic [23:0] a, input logic h);
    exp_fwd.push_back(ref_fwd(a, h, ceil_v, bios_cs_contain));
    i_imf_far_model.isa_access(a, h);
  endtask

  // results are matched against the oldest note as they appear
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      if (exp_rd.size() == 0) chk("rd extra", 34'h0, 34'h1);
      else chk("rdata", exp_rd.pop_front(), {s_axi_rresp, s_axi_rdata});
    end
    if (fwd_valid === 1'b1) begin
      if (exp_fwd.size() == 0) chk("fwd extra", 34'h0, 34'h1);
      else chk("fwd_to_pci", {33'h0, exp_fwd.pop_front()},
               {33'h0, fwd_to_pci});
    end
    if (cpu_plain_retry === 1'b1 || cpu_normal === 1'b1) begin
      if (exp_cpu.size() == 0) chk("cpu extra", 34'h0, 34'h1);
      else chk("cpu answer", {32'h0, exp_cpu.pop_front()},
               {32'h0, cpu_plain_retry, cpu_normal});
    end
  end

  initial begin
    #400000;
    chk("watchdog", 34'h0, 34'h1);
    conclude();
  end

  initial begin
    s_axi_awaddr = 12'h0;
    s_axi_araddr = 12'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    bios_cs_contain = 1'b0;
    ceil_v = 8'h02;
    void'($urandom(32'hd7a8));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(imf_pkg::ADDR_CEIL, 34'h2);
    rd(imf_pkg::ADDR_MISC, 34'h0);
    rd(imf_pkg::ADDR_IRQ_STAT, 34'h0);
    rd(imf_pkg::ADDR_IRQ_MASK, 34'h0);
    rd(12'h004, {imf_pkg::RESP_SLVERR, 32'h0});
    wr(12'h004, 32'hffffffff, 4'hf, imf_pkg::RESP_SLVERR);
    isa(24'h08_1234, 1'b0);
    isa(24'h10_0000, 1'b0);
    setc(8'hff);
    rd(imf_pkg::ADDR_CEIL, 34'hfe);
    $display("test reset done");
    for (int n = 0; n < 16; n++) begin
      setc({4'(n), 4'h0});
      isa({4'(n), 20'($urandom)}, 1'b0);
      isa({4'(n), 20'hfffff}, 1'b0);
      if (n < 15) isa({4'(n) + 4'h1, 20'h0}, 1'b0);
      isa({4'(n), 20'($urandom)}, 1'b1);
    end
    $display("test ceiling done");
    for (int m = 0; m < 16; m++) begin
      bios_cs_contain <= m[3];
      setc({4'hf, 3'(m), 1'b0});
      isa(24'h0e0000 | 24'($urandom & 32'hffff), 1'b0);
      isa(24'h0a0000 | 24'($urandom & 32'h1ffff), 1'b0);
      isa(24'h080000 | 24'($urandom & 32'h1ffff), 1'b0);
      isa(24'h0dffff, 1'b0);
      isa(24'h0f0000, 1'b0);
    end
    $display("test regions done");
    rd(imf_pkg::ADDR_IRQ_STAT, 34'h2);
    rd(imf_pkg::ADDR_IRQ_STAT, 34'h0);
    i_imf_far_model.dt_pulse();
    #1 chk("serr_n low", 34'h0, {33'h0, serr_n});
    @(posedge aclk);
    #1 chk("serr_n high", 34'h1, {33'h0, serr_n});
    chk("irq masked", 34'h0, {33'h0, irq});
    rd(imf_pkg::ADDR_MISC, 34'h8000);
    wr(imf_pkg::ADDR_MISC, 32'h0, 4'h3, imf_pkg::RESP_OKAY);
    rd(imf_pkg::ADDR_MISC, 34'h8000);
    rd(imf_pkg::ADDR_IRQ_STAT, 34'h1);
    wr(imf_pkg::ADDR_IRQ_MASK, 32'h3, 4'h1, imf_pkg::RESP_OKAY);
    i_imf_far_model.dt_pulse();
    @(posedge aclk);
    #1 chk("irq set", 34'h1, {33'h0, irq});
    rd(imf_pkg::ADDR_IRQ_STAT, 34'h1);
    repeat (2) @(posedge aclk);
    #1 chk("irq clear", 34'h0, {33'h0, irq});
    wr(imf_pkg::ADDR_MISC, 32'h8000, 4'h3, imf_pkg::RESP_OKAY);
    rd(imf_pkg::ADDR_MISC, 34'h0);
    $display("test timeout flag done");
    for (int i = 0; i < 8; i++) begin
      lk = 1'($urandom);
      exp_cpu.push_back(2'b01);
      i_imf_far_model.cpu_cycle(lk);
    end
    // no delayed transaction is pending here
    wr(imf_pkg::ADDR_MISC, 32'h80, 4'h1, imf_pkg::RESP_OKAY);
    rd(imf_pkg::ADDR_MISC, 34'h80);
    for (int i = 0; i < 8; i++) begin
      lk = 1'($urandom);
      exp_cpu.push_back({~lk, lk});
      i_imf_far_model.cpu_cycle(lk);
    end
    repeat (3) @(posedge aclk);
    $display("test cpu retry done");
    chk("queues", 34'h0,
        34'(exp_rd.size() + exp_fwd.size() + exp_cpu.size()));
    conclude();
  end
endmodule
